// ===== verilog/adc_ctrl_pkg.sv
// shared constants for the converter control block
package adc_ctrl_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CONTROL   = 12'h111;
  localparam logic [11:0] IDX_IRQ_STAT  = 12'h112;
  localparam logic [11:0] IDX_IRQ_MASK  = 12'h113;
  localparam logic [11:0] IDX_CLK_DIV   = 12'h114;
  localparam logic [11:0] IDX_RESULT    = 12'h115;
  localparam logic [11:0] IDX_PREVIOUS  = 12'h116;
  localparam logic [11:0] IDX_THRESHOLD = 12'h117;
  localparam int          ADDR_W        = 14;
  // control register bit positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_CONTINUOUS_ENABLE   = 6;
  localparam int BIT_CLKSEL = 4;
  localparam int BIT_JUSTIFY = 2;
  localparam int BIT_RUN    = 0;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'hD5;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  // interrupt status bit positions
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_THRESH = 1;
  localparam int IRQ_W      = 2;
  // threshold register layout
  localparam int BIT_SOI    = 16;
  // converter sizes
  localparam int RES_W      = 12;
  localparam int VIEW_W     = 16;
  localparam int DIV_W      = 6;
  localparam logic [RES_W-1:0] RES_MSB = 12'h800;
  localparam logic [3:0]       STEP_LAST = 4'h0;
  localparam logic [3:0]       STEP_FIRST = 4'hB;
  typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} conv_state_t;
endpackage

// ===== verilog/conv_clock_gen.sv
// conversion clock step generator: rc oscillator tick or divided pclk
`timescale 1ns/100ps
module conv_clock_gen (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // configuration
  input  wire logic                          run,
  input  wire logic                          use_rc,
  input  wire logic [adc_ctrl_pkg::DIV_W-1:0] divider,
  // dedicated rc oscillator tick, synchronous to pclk
  input  wire logic                          rc_tick,
  // one-cycle conversion step
  output logic                               step
);
  logic [adc_ctrl_pkg::DIV_W-1:0] count_ff;
  logic [adc_ctrl_pkg::DIV_W-1:0] nxt_count;
  logic                           step_ff;
  logic                           div_wrap;
  logic                           nxt_step;

  // divided system clock wraps after divider+1 cycles
  assign div_wrap  = (count_ff == divider);
  assign nxt_count = (!run || div_wrap) ? '0
                     : count_ff + 1'b1;
  assign nxt_step  = run && (use_rc ? rc_tick : div_wrap); // R6
  assign step      = step_ff;

  // divider counter and registered step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
      step_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      step_ff  <= nxt_step;
    end
  end
endmodule

// ===== verilog/adc_conversion_control.sv
// converter control register, successive approximation sequencer, apb slave
// How it works
// [R1] The converter is powered and may convert only while enable bit 7 is set; clearing it stops everything.
// [R2] Writing one to the run flag starts a conversion and the flag reads one while a conversion runs.
// [R3] The run flag starts or sustains a conversion only while the enable bit is set.
// [R4] With continuous operation off, hardware clears the run flag when the conversion completes.
// [R5] With continuous operation on, a new conversion follows each completion until the threshold flag sets with stop-on-interrupt, or software clears the run flag.
// [R6] The clock-select bit picks the rc oscillator when one and the divided system clock when zero.
// [R7] The justify bit makes current and previous results right-justified when one, left-justified zero-filled when zero.
// [R8] Clearing the run flag mid-conversion stores the partial value as the result and returns the sequencer to idle.
// [R9] An aborted conversion sets no done flag and skips threshold comparison.
// [R10] Control bits 5, 3 and 1 read zero and ignore writes; implemented bits reset to zero.
// [R11] Setting the run flag while the enable bit is clear starts nothing and leaves the run flag clear.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module adc_conversion_control (
  // apb clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // apb slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                         pwdata,
  output logic [31:0]                              prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // analog front end
  input  wire logic                                comp_high,
  input  wire logic                                rc_tick,
  output logic                                     converter_power,
  output logic                                     sample_hold,
  output logic [adc_ctrl_pkg::RES_W-1:0]           dac_code,
  // interrupt
  output logic                                     irq
);
  // right or left alignment of a raw result
  // unused low bits are zero-filled in the left-justified view
  function automatic logic [adc_ctrl_pkg::VIEW_W-1:0] justify(
    input logic [adc_ctrl_pkg::RES_W-1:0] raw,
    input logic                           right
  );
    justify = right ? {4'h0, raw} : {raw, 4'h0}; // R7
  endfunction

  // registers
  logic [7:0]                        ctrl_ff;
  logic [adc_ctrl_pkg::IRQ_W-1:0]    stat_ff;
  logic [adc_ctrl_pkg::IRQ_W-1:0]    mask_ff;
  logic [adc_ctrl_pkg::DIV_W-1:0]    div_ff;
  logic [adc_ctrl_pkg::RES_W-1:0]    result_ff;
  logic [adc_ctrl_pkg::RES_W-1:0]    prev_ff;
  logic [adc_ctrl_pkg::RES_W-1:0]    thresh_ff;
  logic                              soi_ff;
  // decided bits plus the current trial bit, the trial bit alone, and
  // the number of trials still to go, the last one at zero
  logic [adc_ctrl_pkg::RES_W-1:0]    sar_ff;
  logic [adc_ctrl_pkg::RES_W-1:0]    trial_ff;
  logic [3:0]                        bit_ff;
  logic [31:0]                       prdata_ff;
  adc_ctrl_pkg::conv_state_t         state_ff;

  // next values
  logic [7:0]                        nxt_ctrl;
  logic [adc_ctrl_pkg::IRQ_W-1:0]    nxt_stat;
  logic [adc_ctrl_pkg::RES_W-1:0]    nxt_sar;
  logic [adc_ctrl_pkg::RES_W-1:0]    nxt_trial;
  logic [3:0]                        nxt_bit;
  logic [31:0]                       nxt_prdata;
  adc_ctrl_pkg::conv_state_t         nxt_state;

  // decode wires
  logic [11:0] idx;
  logic        setup;
  logic        wr_en;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_div;
  logic        hit_res;
  logic        hit_prev;
  logic        hit_thr;
  logic        mapped;
  logic        en;
  logic        run;
  logic        wr_ctrl;
  logic        sw_start;
  logic        sw_abort;
  logic        step;
  logic        last_step;
  logic        complete;
  logic        commit;
  logic        thr_hit;
  logic        stop_now;
  logic [adc_ctrl_pkg::RES_W-1:0] sar_kept;
  logic [adc_ctrl_pkg::RES_W-1:0] sar_partial;
  logic                           busy;

  // apb address decode; the two low address bits are ignored
  // no wait states: every access phase completes in its first cycle
  assign idx      = paddr[adc_ctrl_pkg::ADDR_W-1:2];
  assign hit_ctrl = (idx == adc_ctrl_pkg::IDX_CONTROL);
  assign hit_stat = (idx == adc_ctrl_pkg::IDX_IRQ_STAT);
  assign hit_mask = (idx == adc_ctrl_pkg::IDX_IRQ_MASK);
  assign hit_div  = (idx == adc_ctrl_pkg::IDX_CLK_DIV);
  assign hit_res  = (idx == adc_ctrl_pkg::IDX_RESULT);
  assign hit_prev = (idx == adc_ctrl_pkg::IDX_PREVIOUS);
  assign hit_thr  = (idx == adc_ctrl_pkg::IDX_THRESHOLD);
  assign mapped   = hit_ctrl | hit_stat | hit_mask | hit_div
                  | hit_res | hit_prev | hit_thr;
  assign setup    = psel & ~penable;
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~mapped;
  assign wr_en    = psel & penable & pwrite & mapped;
  assign prdata   = prdata_ff;

  // control field views
  assign en  = ctrl_ff[adc_ctrl_pkg::BIT_ENABLE];
  assign run = ctrl_ff[adc_ctrl_pkg::BIT_RUN];
  assign busy     = (state_ff == adc_ctrl_pkg::ST_CONVERT);
  assign wr_ctrl  = wr_en & hit_ctrl;
  // a run write with enable clear is dropped here, never held back
  assign sw_start = wr_ctrl & pwdata[adc_ctrl_pkg::BIT_RUN]
                  & pwdata[adc_ctrl_pkg::BIT_ENABLE]; // R3 R11
  assign sw_abort = wr_ctrl & ~pwdata[adc_ctrl_pkg::BIT_RUN]
                  & busy; // R8

  // conversion step source; its counter restarts with every conversion,
  // so with the divided clock the first step comes a full period later
  conv_clock_gen u_clk (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (busy),
    .use_rc  (ctrl_ff[adc_ctrl_pkg::BIT_CLKSEL]),
    .divider (div_ff),
    .rc_tick (rc_tick),
    .step    (step)
  );

  // successive approximation: keep the trial bit if the input is above it
  // comp_high must have settled on the shown code before the next step,
  // so a divider of zero leaves the comparator a single cycle
  assign sar_partial = sar_ff & ~trial_ff; // R8
  assign sar_kept  = comp_high ? sar_ff : sar_partial;
  assign last_step = (bit_ff == adc_ctrl_pkg::STEP_LAST);
  assign complete  = busy & step
                   & last_step & en & ~sw_abort;
  // an abort in the cycle of the last step wins, so no flag follows it
  assign commit    = complete | (sw_abort & en);
  // threshold compare runs only on a finished conversion; a result equal
  // to the threshold does not trip it
  assign thr_hit   = complete & (sar_kept > thresh_ff); // R9
  // with stop-on-interrupt set, a threshold flag still pending also stops a continuous run
  assign stop_now  = soi_ff & (thr_hit | stat_ff[adc_ctrl_pkg::IRQ_THRESH]);

  // run flag and control register next value; the enable test comes last
  // so that no path leaves the run flag set while the converter is off
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = pwdata[7:0] & adc_ctrl_pkg::CTRL_IMPL_MASK; // R10
      nxt_ctrl[adc_ctrl_pkg::BIT_RUN] = sw_start | (run
        & pwdata[adc_ctrl_pkg::BIT_RUN] & pwdata[adc_ctrl_pkg::BIT_ENABLE]);
    end
    if (complete) begin
      if (!ctrl_ff[adc_ctrl_pkg::BIT_CONTINUOUS_ENABLE] || stop_now) begin
        nxt_ctrl[adc_ctrl_pkg::BIT_RUN] = 1'b0; // R4 R5
      end
    end
    if (!nxt_ctrl[adc_ctrl_pkg::BIT_ENABLE]) begin
      nxt_ctrl[adc_ctrl_pkg::BIT_RUN] = 1'b0; // R1 R3
    end
  end

  // conversion sequencer; a run write while busy keeps the conversion
  // going, since a restart would throw away the bits already decided
  always_comb begin
    nxt_state = state_ff;
    nxt_sar   = sar_ff;
    nxt_trial = trial_ff;
    nxt_bit   = bit_ff;
    unique case (state_ff)
      adc_ctrl_pkg::ST_IDLE: begin
        if (nxt_ctrl[adc_ctrl_pkg::BIT_RUN] && !run) begin
          nxt_state = adc_ctrl_pkg::ST_CONVERT; // R2
          nxt_sar   = adc_ctrl_pkg::RES_MSB;
          nxt_trial = adc_ctrl_pkg::RES_MSB;
          nxt_bit   = adc_ctrl_pkg::STEP_FIRST;
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        if (!nxt_ctrl[adc_ctrl_pkg::BIT_RUN]) begin
          nxt_state = adc_ctrl_pkg::ST_IDLE; // R1 R4 R8
        end else if (complete) begin
          nxt_sar   = adc_ctrl_pkg::RES_MSB; // R5
          nxt_trial = adc_ctrl_pkg::RES_MSB;
          nxt_bit   = adc_ctrl_pkg::STEP_FIRST;
        end else if (step) begin
          nxt_trial = trial_ff >> 1;
          nxt_sar   = sar_kept | (trial_ff >> 1);
          nxt_bit   = bit_ff - 4'h1;
        end
      end
    endcase
  end

  // interrupt status: hardware set wins over write-one-to-clear
  // both flags come only from a finished conversion, never an abort
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_en && hit_stat) begin
      nxt_stat = stat_ff & ~pwdata[adc_ctrl_pkg::IRQ_W-1:0];
    end
    if (complete) begin
      nxt_stat[adc_ctrl_pkg::IRQ_DONE] = 1'b1; // R9
    end
    if (thr_hit) begin
      nxt_stat[adc_ctrl_pkg::IRQ_THRESH] = 1'b1;
    end
  end

  // read data mux, captured in the setup cycle
  // the result view follows the justify bit at read time, so changing it
  // re-formats results already stored
  always_comb begin
    nxt_prdata = prdata_ff;
    if (setup) begin
      nxt_prdata = '0;
      if (hit_ctrl) nxt_prdata[7:0] = ctrl_ff; // R2 R10
      if (hit_stat) nxt_prdata[adc_ctrl_pkg::IRQ_W-1:0] = stat_ff;
      if (hit_mask) nxt_prdata[adc_ctrl_pkg::IRQ_W-1:0] = mask_ff;
      if (hit_div)  nxt_prdata[adc_ctrl_pkg::DIV_W-1:0] = div_ff;
      if (hit_res) begin
        nxt_prdata[adc_ctrl_pkg::VIEW_W-1:0] =
          justify(result_ff, ctrl_ff[adc_ctrl_pkg::BIT_JUSTIFY]); // R7
      end
      if (hit_prev) begin
        nxt_prdata[adc_ctrl_pkg::VIEW_W-1:0] =
          justify(prev_ff, ctrl_ff[adc_ctrl_pkg::BIT_JUSTIFY]); // R7
      end
      if (hit_thr) begin
        nxt_prdata[adc_ctrl_pkg::RES_W-1:0] = thresh_ff;
        nxt_prdata[adc_ctrl_pkg::BIT_SOI]   = soi_ff;
      end
    end
  end

  // analog controls; the dac shows the code under trial while busy
  // and keeps its last code when idle
  assign converter_power = en; // R1
  assign sample_hold     = busy;
  assign dac_code        = sar_ff;
  assign irq             = |(stat_ff & mask_ff);

  // control, status and sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= adc_ctrl_pkg::CTRL_RESET; // R10
      stat_ff   <= '0;
      state_ff  <= adc_ctrl_pkg::ST_IDLE;
      sar_ff    <= '0;
      trial_ff  <= '0;
      bit_ff    <= '0;
      prdata_ff <= '0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      stat_ff   <= nxt_stat;
      state_ff  <= nxt_state;
      sar_ff    <= nxt_sar;
      trial_ff  <= nxt_trial;
      bit_ff    <= nxt_bit;
      prdata_ff <= nxt_prdata;
    end
  end

  // software configuration registers
  // change the divider only while idle: a smaller value mid-conversion
  // can stretch one step until the counter wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff   <= '0;
      div_ff    <= '0;
      thresh_ff <= '0;
      soi_ff    <= 1'b0;
    end else if (wr_en) begin
      if (hit_mask) mask_ff <= pwdata[adc_ctrl_pkg::IRQ_W-1:0];
      if (hit_div)  div_ff  <= pwdata[adc_ctrl_pkg::DIV_W-1:0];
      if (hit_thr) begin
        thresh_ff <= pwdata[adc_ctrl_pkg::RES_W-1:0];
        soi_ff    <= pwdata[adc_ctrl_pkg::BIT_SOI];
      end
    end
  end

  // result and previous result; aborts store the partial value
  // the previous result moves only when a new result lands, so a disable
  // written with the run bit still set leaves both untouched unless it lands in the cycle of the last step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= '0;
      prev_ff   <= '0;
    end else if (commit) begin
      result_ff <= complete ? sar_kept : sar_partial; // R8
      prev_ff   <= result_ff;
    end
  end
endmodule

// ===== tb/adc_conversion_control_monitor.sv
// concurrent checks on the converter control block ports
`timescale 1ns/100ps
module adc_conversion_control_monitor (
  // clock and reset
  input wire logic                               pclk,
  input wire logic                               presetn,
  // apb side
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0]    paddr,
  input wire logic [31:0]                        pwdata,
  input wire logic [31:0]                        prdata,
  // front end
  input wire logic                               rc_tick,
  input wire logic                               converter_power,
  input wire logic                               sample_hold,
  input wire logic [adc_ctrl_pkg::RES_W-1:0]     dac_code,
  input wire logic                               irq
);
  // control writes and a shadow of the clock select
  logic rc_sel_ff;
  wire  ctrl_wr = psel && penable && pwrite &&
                  (paddr == {adc_ctrl_pkg::IDX_CONTROL, 2'b00});
  wire  go_wr   = ctrl_wr && pwdata[7] && pwdata[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rc_sel_ff <= 1'b0;
    else if (ctrl_wr) rc_sel_ff <= pwdata[4];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // software clears the run flag during a conversion
  sequence abort_wr;
    ctrl_wr && pwdata[7] && !pwdata[0] && sample_hold;
  endsequence
  // rc clock selected and no oscillator tick for three cycles
  sequence quiet_rc;
    (sample_hold && rc_sel_ff && !rc_tick)[*3];
  endsequence
  chk_power_gate: assert property (
    !converter_power ##1 !converter_power |-> !sample_hold)
    else $error("converting while unpowered");
  chk_go_start: assert property (
    go_wr && !sample_hold |-> ##[1:2] sample_hold)
    else $error("run write did not start");
  chk_start_code: assert property (
    $rose(sample_hold) |-> dac_code == 12'h800)
    else $error("first trial code wrong");
  chk_start_cause: assert property (
    $rose(sample_hold) |-> $past(go_wr) || $past(go_wr, 2))
    else $error("conversion began without enabled run write");
  chk_no_enable: assert property (
    ctrl_wr && !pwdata[7] |-> ##2 !sample_hold)
    else $error("converting with enable clear");
  chk_abort_idle: assert property (
    abort_wr |-> ##2 !sample_hold)
    else $error("abort left sequencer busy");
  chk_abort_noflag: assert property (
    abort_wr |=> $stable(irq) [*2])
    else $error("abort changed interrupt");
  chk_ctrl_reserved: assert property (
    psel && penable && !pwrite &&
    paddr == {adc_ctrl_pkg::IDX_CONTROL, 2'b00} |->
    (prdata & 32'hFFFFFF2A) == 32'h0)
    else $error("reserved control bits set");
  chk_rc_clock: assert property (
    quiet_rc ##1 sample_hold |-> $stable(dac_code))
    else $error("trial code moved without rc tick");
endmodule
bind adc_conversion_control adc_conversion_control_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .rc_tick(rc_tick), .converter_power(converter_power),
  .sample_hold(sample_hold), .dac_code(dac_code), .irq(irq));

// ===== tb/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module testbench;
  // stimulus and observed signals
  logic        pclk, presetn, psel, penable, pwrite, comp_high, rc_tick;
  logic        pready, pslverr, converter_power, sample_hold, irq, jr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, exp_q[$];
  logic [11:0] dac_code, vin, vin_old;
  int          n_fail, n_tests, seed;
  adc_conversion_control i_adc_conversion_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_high(comp_high),
    .rc_tick(rc_tick), .converter_power(converter_power),
    .sample_hold(sample_hold), .dac_code(dac_code), .irq(irq));
  // clock and comparator model with half-step offset so ties never occur
  always #4 pclk = ~pclk;
  always @(posedge pclk) comp_high <= ({vin, 1'b1} > {dac_code, 1'b0});
  task automatic check(input logic [31:0] seen, exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] idx, input logic w,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    apb(idx, 1'b0, 32'h0);
  endtask
  function automatic logic [31:0] view(logic [11:0] v, logic r);
    return r ? {20'h0, v} : {16'h0, v, 4'h0};
  endfunction
  // bounded wait for the sequencer to go idle after a start
  task automatic wait_idle;
    int k;
    k = 0;
    repeat (2) @(posedge pclk);
    while (sample_hold !== 1'b0 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (sample_hold !== 1'b0) begin
      n_fail++;
      end_sim;
    end
  endtask
  // compare each completed read with the oldest noted value
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite)
      check(prdata, exp_q.pop_front(), "read data");
    if (psel && penable)
      check({31'h0, pslverr}, {31'h0, paddr[13:2] > 12'h117}, "slverr");
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; rc_tick = 0; comp_high = 0; vin = 0;
    n_fail = 0; n_tests = 0; seed = 75;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check({31'h0, converter_power}, 32'h0, "power at reset");
    rd(adc_ctrl_pkg::IDX_CONTROL, 32'h0);
    wr(adc_ctrl_pkg::IDX_CONTROL, 32'h2A);
    rd(adc_ctrl_pkg::IDX_CONTROL, 32'h0);
    wr(adc_ctrl_pkg::IDX_CONTROL, 32'h01);
    rd(adc_ctrl_pkg::IDX_CONTROL, 32'h0);
    rd(12'h118, 32'h0);
    $display("test reset and refusals done");
    wr(adc_ctrl_pkg::IDX_CLK_DIV, 32'h2);
    for (int i = 0; i < 2; i++) begin
      jr = (i == 0);
      vin_old = vin;
      vin = 12'($random(seed));
      wr(adc_ctrl_pkg::IDX_IRQ_MASK, {31'h0, jr});
      wr(adc_ctrl_pkg::IDX_CONTROL, {29'h10, jr, 2'h1});
      wait_idle;
      check({31'h0, converter_power}, 32'h1, "power on");
      rd(adc_ctrl_pkg::IDX_CONTROL, {29'h10, jr, 2'h0});
      rd(adc_ctrl_pkg::IDX_RESULT, view(vin, jr));
      rd(adc_ctrl_pkg::IDX_PREVIOUS, view(vin_old, jr));
      // threshold is zero here, so any nonzero result also trips it
      rd(adc_ctrl_pkg::IDX_IRQ_STAT, {30'h0, vin > 12'h0, 1'b1});
      check({31'h0, irq}, {31'h0, jr}, "done interrupt");
      wr(adc_ctrl_pkg::IDX_IRQ_STAT, 32'h3);
      rd(adc_ctrl_pkg::IDX_IRQ_STAT, 32'h0);
      check({31'h0, irq}, 32'h0, "interrupt cleared");
    end
    $display("test single conversions done");
    wr(adc_ctrl_pkg::IDX_CONTROL, 32'hC5);
    repeat (100) @(posedge pclk);
    rd(adc_ctrl_pkg::IDX_CONTROL, 32'hC5);
    wr(adc_ctrl_pkg::IDX_CONTROL, 32'hC4);
    rd(adc_ctrl_pkg::IDX_CONTROL, 32'hC4);
    wr(adc_ctrl_pkg::IDX_IRQ_STAT, 32'h3);
    wr(adc_ctrl_pkg::IDX_THRESHOLD, 32'h10000);
    vin = 12'($random(seed)) | 12'h1;
    wr(adc_ctrl_pkg::IDX_CONTROL, 32'hC5);
    wait_idle;
    rd(adc_ctrl_pkg::IDX_CONTROL, 32'hC4);
    rd(adc_ctrl_pkg::IDX_IRQ_STAT, 32'h3);
    $display("test continuous mode done");
    wr(adc_ctrl_pkg::IDX_IRQ_STAT, 32'h3);
    wr(adc_ctrl_pkg::IDX_IRQ_MASK, 32'h3);
    vin = 12'($random(seed)) | 12'h800;
    wr(adc_ctrl_pkg::IDX_CONTROL, 32'h95);
    repeat (20) @(posedge pclk);
    check({20'h0, dac_code}, 32'h800, "code moved without tick");
    rc_tick <= 1'b1;
    @(posedge pclk);
    rc_tick <= 1'b0;
    repeat (4) @(posedge pclk);
    check({20'h0, dac_code}, 32'hC00, "code after one tick");
    wr(adc_ctrl_pkg::IDX_CONTROL, 32'h94);
    rd(adc_ctrl_pkg::IDX_CONTROL, 32'h94);
    rd(adc_ctrl_pkg::IDX_RESULT, 32'h800);
    rd(adc_ctrl_pkg::IDX_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0, "interrupt after abort");
    $display("test rc clock and abort done");
    end_sim;
  end
endmodule
